// File: src/pmrr_math.sv
// Clamp, current and power pipeline of the power monitor.
`timescale 1ns/1ps
`default_nettype none
module pmrr_math
  import pmrr_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rstN,
  input  wire logic               measValid,
  input  wire logic signed [16:0] shuntRaw,
  input  wire logic        [12:0] busRaw,
  input  wire logic        [1:0]  gainSel,
  input  wire logic        [15:0] scale,
  pmrr_result_if.producer         res
);
  logic               s1Valid_q;
  logic        [15:0] s1Shunt_q;
  logic        [12:0] s1Bus_q;
  logic               s2Valid_q;
  logic        [15:0] s2Shunt_q;
  logic        [12:0] s2Bus_q;
  logic        [15:0] s2Current_q;
  logic               s2Ovf_q;
  logic signed [16:0] fullScale;
  logic signed [16:0] clamped;
  logic signed [32:0] curProd;
  logic signed [32:0] curFull;
  logic               curOvf;
  logic        [15:0] curMag;
  logic        [28:0] pwrProd;
  logic        [28:0] pwrQuot;

  always_comb begin
    case (gainSel)
      2'h0:    fullScale = PMRR_FS_GAIN1;
      2'h1:    fullScale = PMRR_FS_GAIN2;
      2'h2:    fullScale = PMRR_FS_GAIN4;
      default: fullScale = PMRR_FS_GAIN8;
    endcase
    // Readings past full scale stick at the full-scale code.
    if (shuntRaw > fullScale) begin
      clamped = fullScale;
    end else if (shuntRaw < -fullScale) begin
      clamped = -fullScale;
    end else begin
      clamped = shuntRaw;
    end
  end

  // Bit 0 of the scale never enters the product.
  assign curProd = $signed(s1Shunt_q) * $signed({1'b0, scale[15:1], 1'b0});
  assign curFull = curProd >>> PMRR_CUR_SHIFT;
  assign curOvf  = curFull[32:15] != {18{curFull[32]}};
  assign curMag  = s2Current_q[15] ? 16'(-s2Current_q) : s2Current_q;
  assign pwrProd = curMag * s2Bus_q;
  assign pwrQuot = pwrProd / PMRR_POWER_DIV;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s1Valid_q <= 1'b0;
      s1Shunt_q <= PMRR_RESULT_RESET;
      s1Bus_q   <= PMRR_BUS_RESET;
    end else begin
      s1Valid_q <= measValid;
      if (measValid) begin
        s1Shunt_q <= clamped[15:0];
        s1Bus_q   <= busRaw;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s2Valid_q   <= 1'b0;
      s2Shunt_q   <= PMRR_RESULT_RESET;
      s2Bus_q     <= PMRR_BUS_RESET;
      s2Current_q <= PMRR_RESULT_RESET;
      s2Ovf_q     <= 1'b0;
    end else begin
      s2Valid_q <= s1Valid_q;
      if (s1Valid_q) begin
        s2Shunt_q   <= s1Shunt_q;
        s2Bus_q     <= s1Bus_q;
        s2Current_q <= curFull[15:0];
        s2Ovf_q     <= curOvf;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      res.done    <= 1'b0;
      res.shunt   <= PMRR_RESULT_RESET;
      res.busVal  <= PMRR_BUS_RESET;
      res.current <= PMRR_RESULT_RESET;
      res.power   <= PMRR_RESULT_RESET;
      res.ovf     <= 1'b0;
    end else begin
      res.done <= s2Valid_q;
      if (s2Valid_q) begin
        res.shunt   <= s2Shunt_q;
        res.busVal  <= s2Bus_q;
        res.current <= s2Current_q;
        res.power   <= pwrQuot[15:0];
        res.ovf     <= s2Ovf_q | (|pwrQuot[28:16]);
      end
    end
  end

  property p_shunt_clamp;
    @(posedge clk) disable iff (!rstN)
      measValid && gainSel == 2'h0 && shuntRaw < -PMRR_FS_GAIN1
      |=> s1Shunt_q == 16'hF060;
  endproperty
  a_shunt_clamp: assert property (p_shunt_clamp)
    else $error("Shunt reading not clamped to negative full scale.");

  property p_current_scale;
    @(posedge clk) disable iff (!rstN)
      s1Valid_q && s1Shunt_q == 16'h07D0 && scale == 16'h5000
      |=> s2Current_q == 16'h2710;
  endproperty
  a_current_scale: assert property (p_current_scale)
    else $error("Current result does not match shunt times scale.");

  property p_power_scale;
    @(posedge clk) disable iff (!rstN)
      s2Valid_q && s2Current_q == 16'h2710 && s2Bus_q == 13'h0BB3
      |=> res.power == 16'h1766 && !res.ovf;
  endproperty
  a_power_scale: assert property (p_power_scale)
    else $error("Power result does not match current times bus.");
endmodule // pmrr_math
`default_nettype wire

// File: src/pmrr_pkg.sv
// Shared constants of the power monitor result register bank.
package pmrr_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [7:0] PMRR_ADDR_SHUNT   = 8'h01;
  localparam logic [7:0] PMRR_ADDR_BUS     = 8'h02;
  localparam logic [7:0] PMRR_ADDR_POWER   = 8'h03;
  localparam logic [7:0] PMRR_ADDR_CURRENT = 8'h04;
  localparam logic [7:0] PMRR_ADDR_CAL     = 8'h05;

  // ************************************************************
  // Reset values and field layout
  // ************************************************************
  localparam logic [15:0] PMRR_RESULT_RESET = 16'h0000;
  localparam logic [15:0] PMRR_CAL_RESET    = 16'h0000;
  localparam logic [12:0] PMRR_BUS_RESET    = 13'h0000;
  localparam int          PMRR_BUS_MSB_POS  = 12;

  // ************************************************************
  // Shunt full-scale codes per gain setting
  // ************************************************************
  localparam logic signed [16:0] PMRR_FS_GAIN1 = 17'h00FA0;
  localparam logic signed [16:0] PMRR_FS_GAIN2 = 17'h01F40;
  localparam logic signed [16:0] PMRR_FS_GAIN4 = 17'h03E80;
  localparam logic signed [16:0] PMRR_FS_GAIN8 = 17'h07D00;

  // ************************************************************
  // Arithmetic scaling
  // ************************************************************
  localparam int          PMRR_CUR_SHIFT = 12;
  localparam logic [28:0] PMRR_POWER_DIV = 29'h0001388;

  // ************************************************************
  // Operating modes that leave the ready flag alone
  // ************************************************************
  localparam logic [2:0] PMRR_MODE_POWER_DOWN = 3'h0;
  localparam logic [2:0] PMRR_MODE_ADC_OFF    = 3'h4;

  typedef enum logic {LINK_IDLE, LINK_WAIT} pmrr_link_state_t;

endpackage

// File: src/pmrr_result_if.sv
// Result bundle passed from the arithmetic pipeline to the register bank.
`timescale 1ns/1ps
`default_nettype none
interface pmrr_result_if;
  logic        done;
  logic [15:0] shunt;
  logic [12:0] busVal;
  logic [15:0] current;
  logic [15:0] power;
  logic        ovf;

  modport producer (output done, shunt, busVal, current, power, ovf);
  modport consumer (input  done, shunt, busVal, current, power, ovf);
endinterface
`default_nettype wire

// File: src/pmrr_sync.sv
// Three-stage synchroniser that passes a value once two stages agree.
`timescale 1ns/1ps
`default_nettype none
module pmrr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstN,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end
endmodule // pmrr_sync
`default_nettype wire

// File: src/pmrr_top.sv
// Result and scaling register bank of the shunt power monitor.
// Summary of operation
// - Shunt readings beyond the gain range store that range's full-scale code.
// - Bus register holds latest bus reading in bits 15 to 3, 4 mV steps.
// - With bus range one, all thirteen bus bits are used, up to 1F40.
// - With bus range zero, bus bit 15 reads zero, full scale 0FA0.
// - Ready flag in bus bit 1 sets only after the whole cycle finishes.
// - Results are readable anytime and show the last completed cycle.
// - Writing a new mode clears the ready flag, except power-down or ADC off.
// - Any read of the power register clears the ready flag.
// - Overflow flag in bus bit 0 sets when current or power overflows.
// - Power register is read-only, resets to zero, holds current times bus.
// - Power scaling follows from the calibration contents.
// - Current register is read-only, resets to zero, signed two's complement.
// - Current is the stored shunt reading times the calibration value.
// - Calibration resets to zero; bits 15..1 writable; bit 0 reads zero.
// - Current product is divided by 4096 before storing.
// - Power product of current and bus value is divided by 5000.
// - Shunt value is sign-extended to sixteen bits per the gain setting.
`timescale 1ns/1ps
`default_nettype none
module pmrr_top
  import pmrr_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               linkClk,
  input  wire logic               measValid,
  input  wire logic signed [16:0] shuntRaw,
  input  wire logic        [12:0] busRaw,
  input  wire logic        [1:0]  shuntGainSelect,
  input  wire logic               busRangeSelect,
  input  wire logic               modeWrite,
  input  wire logic        [2:0]  modeCode,
  input  wire logic        [7:0]  regAddr,
  input  wire logic               regRead,
  input  wire logic               regWrite,
  input  wire logic        [15:0] regWrData,
  output var  logic        [15:0] regRdData,
  output var  logic               regRdValid,
  output var  logic               regBusy
);

  // ************************************************************
  // Declarations
  // ************************************************************
  pmrr_result_if     res ();
  pmrr_link_state_t  linkState_q;
  pmrr_link_state_t  linkState_d;
  logic        [7:0] linkAddr_q;
  logic       [15:0] linkWrData_q;
  logic              linkIsWrite_q;
  logic              reqTgl_q;
  logic              ackSync;
  logic              ackSeen_q;
  logic              ackEvt;
  logic              reqSync;
  logic              reqSeen_q;
  logic              reqEvt;
  logic              ackTgl_q;
  logic       [15:0] coreRdData_q;
  logic       [15:0] cal_q;
  logic       [15:0] shunt_q;
  logic       [12:0] busField_q;
  logic       [15:0] current_q;
  logic       [15:0] power_q;
  logic              doneFlag_q;
  logic              ovfFlag_q;
  logic              powerReadEvt;
  logic              modeClearEvt;
  logic              calWriteEvt;
  logic       [15:0] readMux;

  // ************************************************************
  // Arithmetic pipeline
  // ************************************************************
  pmrr_math mathU (
    .clk       (core_clk),
    .rstN      (rst_n),
    .measValid (measValid),
    .shuntRaw  (shuntRaw),
    .busRaw    (busRaw),
    .gainSel   (shuntGainSelect),
    .scale     (cal_q),
    .res       (res.producer)
  );

  // ************************************************************
  // Link side: accept one access at a time
  // ************************************************************
  // A second access while one is in flight is dropped; regBusy tells
  // the serial engine to hold it, which keeps the handshake simple.
  always_comb begin
    linkState_d = linkState_q;
    case (linkState_q)
      LINK_IDLE: begin
        if (regRead || regWrite) begin
          linkState_d = LINK_WAIT;
        end
      end
      LINK_WAIT: begin
        if (ackEvt) begin
          linkState_d = LINK_IDLE;
        end
      end
      default: linkState_d = LINK_IDLE;
    endcase
  end

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      linkState_q <= LINK_IDLE;
      regBusy     <= 1'b0;
    end else begin
      linkState_q <= linkState_d;
      regBusy     <= linkState_d == LINK_WAIT;
    end
  end

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      linkAddr_q    <= 8'h00;
      linkWrData_q  <= 16'h0000;
      linkIsWrite_q <= 1'b0;
      reqTgl_q      <= 1'b0;
    end else if (linkState_q == LINK_IDLE && (regRead || regWrite)) begin
      linkAddr_q    <= regAddr;
      linkWrData_q  <= regWrData;
      linkIsWrite_q <= regWrite;
      reqTgl_q      <= ~reqTgl_q;
    end
  end

  pmrr_sync #(.W(1)) ackSyncU (
    .clk  (linkClk),
    .rstN (rst_n),
    .d    (ackTgl_q),
    .q    (ackSync)
  );

  assign ackEvt = ackSync != ackSeen_q;

  // The answer word is stable in the core domain well before the
  // acknowledge toggle has crossed, so it is sampled here directly.
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      ackSeen_q  <= 1'b0;
      regRdData  <= 16'h0000;
      regRdValid <= 1'b0;
    end else begin
      ackSeen_q  <= ackSync;
      regRdValid <= ackEvt && !linkIsWrite_q;
      if (ackEvt && !linkIsWrite_q) begin
        regRdData <= coreRdData_q;
      end
    end
  end

  // ************************************************************
  // Core side: perform the access
  // ************************************************************
  pmrr_sync #(.W(1)) reqSyncU (
    .clk  (core_clk),
    .rstN (rst_n),
    .d    (reqTgl_q),
    .q    (reqSync)
  );

  assign reqEvt       = reqSync != reqSeen_q;
  assign powerReadEvt = reqEvt && !linkIsWrite_q
                        && linkAddr_q == PMRR_ADDR_POWER;
  assign calWriteEvt  = reqEvt && linkIsWrite_q
                        && linkAddr_q == PMRR_ADDR_CAL;
  assign modeClearEvt = modeWrite && modeCode != PMRR_MODE_POWER_DOWN
                        && modeCode != PMRR_MODE_ADC_OFF;

  always_comb begin
    case (linkAddr_q)
      PMRR_ADDR_SHUNT:   readMux = shunt_q;
      PMRR_ADDR_BUS:     readMux = {busField_q, 1'b0, doneFlag_q,
                                    ovfFlag_q};
      PMRR_ADDR_POWER:   readMux = power_q;
      PMRR_ADDR_CURRENT: readMux = current_q;
      PMRR_ADDR_CAL:     readMux = cal_q;
      default:           readMux = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reqSeen_q    <= 1'b0;
      ackTgl_q     <= 1'b0;
      coreRdData_q <= 16'h0000;
    end else begin
      reqSeen_q <= reqSync;
      if (reqEvt) begin
        coreRdData_q <= readMux;
        ackTgl_q     <= ~ackTgl_q;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_q <= PMRR_CAL_RESET;
    end else if (calWriteEvt) begin
      cal_q <= {linkWrData_q[15:1], 1'b0};
    end
  end

  // ************************************************************
  // Result registers
  // ************************************************************
  // All results land on the same edge so no read mixes two cycles.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shunt_q    <= PMRR_RESULT_RESET;
      busField_q <= PMRR_BUS_RESET;
      current_q  <= PMRR_RESULT_RESET;
      power_q    <= PMRR_RESULT_RESET;
    end else if (res.done) begin
      shunt_q    <= res.shunt;
      current_q  <= res.current;
      power_q    <= res.power;
      busField_q <= res.busVal;
      if (!busRangeSelect) begin
        busField_q[PMRR_BUS_MSB_POS] <= 1'b0;
      end
    end
  end

  // A completion in the same cycle as a clear keeps the flag set.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      doneFlag_q <= 1'b0;
    end else if (res.done) begin
      doneFlag_q <= 1'b1;
    end else if (powerReadEvt || modeClearEvt) begin
      doneFlag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovfFlag_q <= 1'b0;
    end else if (res.done) begin
      ovfFlag_q <= res.ovf;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_bus_full_range;
    @(posedge core_clk) disable iff (!rst_n)
      res.done && busRangeSelect |=> busField_q == $past(res.busVal);
  endproperty
  a_bus_full_range: assert property (p_bus_full_range)
    else $error("Bus value lost bits with full range selected.");

  property p_bus_half_range;
    @(posedge core_clk) disable iff (!rst_n)
      res.done && !busRangeSelect |=> !busField_q[12]
      && busField_q[11:0] == $past(res.busVal[11:0]);
  endproperty
  a_bus_half_range: assert property (p_bus_half_range)
    else $error("Bus top bit not cleared with half range selected.");

  property p_done_after_cycle;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(doneFlag_q) |-> $past(res.done);
  endproperty
  a_done_after_cycle: assert property (p_done_after_cycle)
    else $error("Ready flag set without a finished cycle.");

  property p_mode_clear;
    @(posedge core_clk) disable iff (!rst_n)
      modeClearEvt && !res.done |=> !doneFlag_q;
  endproperty
  a_mode_clear: assert property (p_mode_clear)
    else $error("Ready flag not cleared by a new mode.");

  property p_mode_keep;
    @(posedge core_clk) disable iff (!rst_n)
      doneFlag_q && modeWrite && modeCode == PMRR_MODE_POWER_DOWN
      && !powerReadEvt |=> doneFlag_q;
  endproperty
  a_mode_keep: assert property (p_mode_keep)
    else $error("Ready flag cleared by a power-down write.");

  property p_power_read_clear;
    @(posedge core_clk) disable iff (!rst_n)
      powerReadEvt && !res.done |=> !doneFlag_q
      && coreRdData_q == $past(power_q);
  endproperty
  a_power_read_clear: assert property (p_power_read_clear)
    else $error("Power read did not clear the ready flag.");

  property p_overflow_flag;
    @(posedge core_clk) disable iff (!rst_n)
      res.done |=> ovfFlag_q == $past(res.ovf);
  endproperty
  a_overflow_flag: assert property (p_overflow_flag)
    else $error("Overflow flag does not follow the finished cycle.");

  property p_cal_write;
    @(posedge core_clk) disable iff (!rst_n)
      calWriteEvt |=> cal_q == {$past(linkWrData_q[15:1]), 1'b0};
  endproperty
  a_cal_write: assert property (p_cal_write)
    else $error("Calibration write stored wrong value.");

  property p_results_together;
    @(posedge core_clk) disable iff (!rst_n)
      res.done |=> shunt_q == $past(res.shunt)
      && current_q == $past(res.current) && power_q == $past(res.power);
  endproperty
  a_results_together: assert property (p_results_together)
    else $error("Results did not update together.");

  property p_read_answer;
    @(posedge linkClk) disable iff (!rst_n)
      $rose(regBusy) |-> ##[4:40] !regBusy;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("Register access not answered in time.");

endmodule // pmrr_top
`default_nettype wire

// File: tb/pmrr_host_model.sv
// Host controller model that drives the register link of the monitor.
`timescale 1ns/1ps
`default_nettype none
module pmrr_host_model (
  input  wire logic        linkClk,
  input  wire logic        regBusy,
  input  wire logic        regRdValid,
  input  wire logic [15:0] regRdData,
  output var  logic [7:0]  regAddr,
  output var  logic        regRead,
  output var  logic        regWrite,
  output var  logic [15:0] regWrData
);
  initial begin
    regAddr   = 8'h00;
    regRead   = 1'b0;
    regWrite  = 1'b0;
    regWrData = 16'h0000;
  end

  // ************************************************************
  // One access
  // ************************************************************
  // The request is held for one edge only, because a request still
  // standing when the bank goes idle would be taken a second time.
  // Released lines carry inverted values so stale data cannot pass.
  // The ok output says the answer came in time and of the right kind.
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [15:0] d, output logic [15:0] q,
                        output logic ok);
    int n;
    n = 0;
    while (regBusy !== 1'b0 && n < 80) begin
      @(negedge linkClk);
      n++;
    end
    @(negedge linkClk);
    regAddr   = a;
    regWrData = d;
    regRead   = !wr;
    regWrite  = wr;
    @(negedge linkClk);
    regRead   = 1'b0;
    regWrite  = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
    n = 0;
    while (regBusy === 1'b1 && n < 80) begin
      @(negedge linkClk);
      n++;
    end
    q = regRdData;
    ok = (n < 80) && (regRdValid === !wr);
  endtask
endmodule // pmrr_host_model
`default_nettype wire

// File: tb/pmrr_top_test.sv
// Self-checking testbench of the power monitor result register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  n_errors++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module pmrr_top_test;
  import pmrr_pkg::*;
  logic               core_clk = 1'b0;
  logic               linkClk  = 1'b0;
  logic               rst_n    = 1'b0;
  logic               measValid = 1'b0;
  logic signed [16:0] shuntRaw = 17'h00000;
  logic        [12:0] busRaw = 13'h0000;
  logic        [1:0]  shuntGainSelect = 2'h0;
  logic               busRangeSelect = 1'b0;
  logic               modeWrite = 1'b0;
  logic        [2:0]  modeCode = 3'h0;
  logic        [7:0]  regAddr;
  logic               regRead;
  logic               regWrite;
  logic        [15:0] regWrData;
  logic        [15:0] regRdData;
  logic               regRdValid;
  logic               regBusy;
  int                 n_errors = 0;
  int                 n_compared = 0;

  always #50 core_clk = ~core_clk;
  always #24 linkClk = ~linkClk;

  pmrr_top uut (.core_clk(core_clk), .rst_n(rst_n), .linkClk(linkClk),
    .measValid(measValid), .shuntRaw(shuntRaw), .busRaw(busRaw),
    .shuntGainSelect(shuntGainSelect), .busRangeSelect(busRangeSelect),
    .modeWrite(modeWrite), .modeCode(modeCode), .regAddr(regAddr),
    .regRead(regRead), .regWrite(regWrite), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .regBusy(regBusy));

  pmrr_host_model host (.linkClk(linkClk), .regBusy(regBusy),
    .regRdValid(regRdValid), .regRdData(regRdData), .regAddr(regAddr),
    .regRead(regRead), .regWrite(regWrite), .regWrData(regWrData));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chkReg(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    logic        ok;
    host.access(1'b0, a, 16'h0000, q, ok);
    `CHK(ok, 1'b1)
    `CHK(q, e)
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic        ok;
    host.access(1'b1, a, d, q, ok);
    `CHK(ok, 1'b1)
  endtask

  // Waits well past the four-edge commit so the results have landed.
  task automatic meas(input logic [1:0] g, input logic signed [16:0] s,
                      input logic [12:0] b);
    @(negedge core_clk);
    shuntGainSelect = g;
    shuntRaw = s;
    busRaw = b;
    measValid = 1'b1;
    @(negedge core_clk);
    measValid = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    chkReg(PMRR_ADDR_POWER, 16'h0000);
    chkReg(PMRR_ADDR_CURRENT, 16'h0000);
    chkReg(PMRR_ADDR_CAL, 16'h0000);
    chkReg(PMRR_ADDR_BUS, 16'h0000);
  endtask

  task automatic t_cal;
    wrReg(PMRR_ADDR_CAL, 16'h5001);
    chkReg(PMRR_ADDR_CAL, 16'h5000);
    wrReg(8'h07, 16'hFFFF);
    chkReg(8'h07, 16'h0000);
  endtask

  task automatic t_example;
    @(negedge core_clk);
    busRangeSelect = 1'b0;
    meas(2'h0, 17'sh007D0, 13'h0BB3);
    chkReg(PMRR_ADDR_SHUNT, 16'h07D0);
    chkReg(PMRR_ADDR_CURRENT, 16'h2710);
    chkReg(PMRR_ADDR_BUS, 16'h5D9A);
    chkReg(PMRR_ADDR_POWER, 16'h1766);
    chkReg(PMRR_ADDR_BUS, 16'h5D98);
  endtask

  task automatic t_clamp;
    @(negedge core_clk);
    busRangeSelect = 1'b1;
    meas(2'h0, -17'sd5000, 13'h1F40);
    chkReg(PMRR_ADDR_SHUNT, 16'hF060);
    chkReg(PMRR_ADDR_CURRENT, 16'hB1E0);
    chkReg(PMRR_ADDR_BUS, 16'hFA02);
    chkReg(PMRR_ADDR_POWER, 16'h7D00);
    meas(2'h1, 17'sd9000, 13'h0000);
    chkReg(PMRR_ADDR_SHUNT, 16'h1F40);
    meas(2'h2, -17'sd20000, 13'h0000);
    chkReg(PMRR_ADDR_SHUNT, 16'hC180);
    @(negedge core_clk);
    busRangeSelect = 1'b0;
    meas(2'h0, 17'sh00000, 13'h1F40);
    chkReg(PMRR_ADDR_BUS, 16'h7A02);
  endtask

  task automatic t_ovf;
    @(negedge core_clk);
    busRangeSelect = 1'b1;
    wrReg(PMRR_ADDR_CAL, 16'hFFFE);
    meas(2'h3, 17'sh07D00, 13'h0100);
    chkReg(PMRR_ADDR_BUS, 16'h0803);
  endtask

  task automatic t_mode;
    logic rdy;
    for (int c = 0; c < 8; c++) begin
      meas(2'h0, 17'sh00000, 13'h0010);
      @(negedge core_clk);
      modeCode = c[2:0];
      modeWrite = 1'b1;
      @(negedge core_clk);
      modeWrite = 1'b0;
      rdy = (c == 0 || c == 4) ? 1'b1 : 1'b0;
      chkReg(PMRR_ADDR_BUS, {13'h0010, 1'b0, rdy, 1'b0});
    end
  endtask

  // ************************************************************
  // Sequence and verdict
  // ************************************************************
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    t_reset();
    t_cal();
    t_example();
    t_clamp();
    t_ovf();
    t_mode();
    test_done();
  end

  // Whole run needs well under a tenth of this span.
  initial begin
    #800000;
    n_errors++;
    test_done();
  end
endmodule // pmrr_top_test
`default_nettype wire
